/* design/lsad_decode.sv */
/*
 * Legacy segment attribute decoder: segment attribute registers behind an
 * Avalon-MM slave, plus a per-access route decision below 1 MB and for
 * the fixed 15-16 MB gap.
 * Assumes access requests, VGA steering and SMM space selection arrive
 * from logic on mclk; the route result is registered one cycle later.
 */

// Overview of operation
// [R01] Thirteen segments 768 KB to 1 MB, separate read/write claim, seven registers.
// [R02] Attributes apply to host accesses only; other initiators always reach DRAM.
// [R03] Host read claimed to DRAM when read-claim set, else to PCI path.
// [R04] Host write claimed to DRAM when write-claim set, else to PCI path.
// [R05] Two fields per register: bit 0/4 read-claim, bit 1/5 write-claim, rest reserved.
// [R06] Both claims clear: segment disabled, no target response, everything forwarded.
// [R07] Read-claim only: reads to DRAM, writes forwarded, segment write protected.
// [R08] Write-claim only: writes to DRAM, reads forwarded.
// [R09] Both claims set: reads and writes claimed to DRAM.
// [R10] Software makes a segment read/write before hub or AGP accesses it.
// [R11] Software shadows firmware via write-only, copy, then read-only.
// [R12] F0000-FFFFF is one segment, upper field of first register, lower reserved.
// [R13] C0000-DFFFF: eight 16 KB segments in four registers, low field first.
// [R14] E0000-EFFFF: four 16 KB segments in two registers, low field first.
// [R15] 0 to 7FFFF always decodes to DRAM.
// [R16] 80000-9FFFF to DRAM unless declared a hole, then to PCI path.
// [R17] Video range ignores attributes; goes PCI or AGP unless accessed in SMM.
// [R18] Video range as SMM space blocks hub and AGP initiated accesses.
// [R19] Gap control bit 7 opens a 15-16 MB DRAM hole; bits 6:0 reserved.
// [R20] DRAM under the open gap is not relocated, only unreachable.
// [R21] Reset clears all attribute and gap registers.
// [R22] Each access yields one destination from address, direction, initiator, registers.
module lsad_decode
    import lsad_pkg::*;
#(
    parameter int AVS_ADDR_W = 8
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [AVS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic acc_valid,
    input wire lsad_acc_t acc,
    input wire logic vga_to_agp,
    input wire logic video_smm_space,
    output lsad_route_t route
);

    // ==========================================================
    // Parameter check
    if (AVS_ADDR_W < 8)
    begin : g_bad_addr_w
        $error("avs_address narrower than the register indices");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [LSAD_NUM_ATTR-1:0][7:0] segment_attribute_map;
        logic [7:0] fixed_gap_ctrl;
        logic [7:0] dos_ctrl;
        logic [7:0] status;
        logic waitreq;
        logic [31:0] rdata;
        lsad_route_t route;
    } lsad_state_t;

    lsad_state_t state;
    lsad_state_t next_state;

    logic [LSAD_NUM_SEG-1:0] read_claim_bit;
    logic [LSAD_NUM_SEG-1:0] write_claim_bit;

    // ==========================================================
    // Segment claim bits, one per segment
    for (genvar k = 0; k < LSAD_NUM_SEG; k++)
    begin : g_seg
        if (k == LSAD_NUM_SEG - 1)
        begin : g_sys
            assign read_claim_bit[k] = state.segment_attribute_map[0][LSAD_RD_HI]; // see [R12]
            assign write_claim_bit[k] = state.segment_attribute_map[0][LSAD_WR_HI];
        end
        else
        begin : g_exp
            // Even segment in the low field, odd one in the high field
            localparam int REG = 1 + k / 2;
            localparam int RB = (k % 2 == 0) ? LSAD_RD_LO : LSAD_RD_HI;
            localparam int WB = (k % 2 == 0) ? LSAD_WR_LO : LSAD_WR_HI;
            assign read_claim_bit[k] = state.segment_attribute_map[REG][RB]; // see [R13] [R14]
            assign write_claim_bit[k] = state.segment_attribute_map[REG][WB]; // see [R05]
        end
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        logic [7:0] idx;
        logic [7:0] wbyte;
        logic [7:0] rbyte;
        logic take_wr;
        logic [5:0] blk;
        logic [3:0] seg;
        logic seg_hit;
        logic claim_bit;
        lsad_dest_t dest;
        idx = 8'h00;
        wbyte = avs_writedata[7:0];
        rbyte = 8'h00;
        take_wr = 1'b0;
        blk = 6'h00;
        seg = 4'h0;
        seg_hit = 1'b0;
        claim_bit = 1'b0;
        dest = LSAD_DEST_DRAM;
        next_state = state;

        // Bus slave: one wait state, then the transfer completes
        idx = avs_address[7:0];
        if (AVS_ADDR_W > 8)
        begin
            if (avs_address != AVS_ADDR_W'(idx))
            begin
                idx = 8'h00;
            end
        end
        next_state.waitreq = !((avs_read || avs_write) && state.waitreq);
        take_wr = avs_write && !state.waitreq && avs_byteenable[0];
        case (idx)
            LSAD_IDX_BIOS_AREA:
            begin
                rbyte = state.segment_attribute_map[0];
                if (take_wr)
                begin
                    next_state.segment_attribute_map[0] = wbyte & LSAD_BIOS_MASK; // see [R12]
                end
            end
            LSAD_IDX_ADDON_C0, LSAD_IDX_ADDON_C8, LSAD_IDX_ADDON_D0, LSAD_IDX_ADDON_D8,
            LSAD_IDX_BIOS_E0, LSAD_IDX_BIOS_E8:
            begin
                rbyte = state.segment_attribute_map[3'(idx - LSAD_IDX_BIOS_AREA)];
                if (take_wr)
                begin
                    // Reserved upper bits of each field stay zero
                    next_state.segment_attribute_map[3'(idx - LSAD_IDX_BIOS_AREA)] =
                        wbyte & LSAD_ATTR_MASK; // see [R05] [R01]
                end
            end
            LSAD_IDX_GAP_CTRL:
            begin
                rbyte = state.fixed_gap_ctrl;
                if (take_wr)
                begin
                    next_state.fixed_gap_ctrl = wbyte & LSAD_GAP_MASK; // see [R19]
                end
            end
            LSAD_IDX_DOS_CTRL:
            begin
                rbyte = state.dos_ctrl;
                if (take_wr)
                begin
                    next_state.dos_ctrl = wbyte & LSAD_DOS_MASK;
                end
            end
            LSAD_IDX_STATUS:
            begin
                rbyte = state.status;
            end
            default:
            begin
                rbyte = 8'h00;
            end
        endcase
        if ((avs_read || avs_write) && state.waitreq)
        begin
            next_state.rdata = {24'h00_0000, rbyte};
        end

        // Route decision
        blk = acc.addr[19:14];
        if (acc.addr >= LSAD_EXP_BASE && acc.addr < LSAD_SYS_BIOS_BASE)
        begin
            seg = 4'(blk - LSAD_EXP_BLOCK);
            seg_hit = 1'b1;
        end
        else if (acc.addr >= LSAD_SYS_BIOS_BASE && acc.addr < LSAD_ONE_MEG)
        begin
            seg = LSAD_SYS_BIOS_SEG;
            seg_hit = 1'b1;
        end
        claim_bit = acc.write ? write_claim_bit[seg] : read_claim_bit[seg];

        if (acc.addr < LSAD_DOS_LOW_END)
        begin
            dest = LSAD_DEST_DRAM; // see [R15]
        end
        else if (acc.addr < LSAD_VIDEO_BASE)
        begin
            dest = state.dos_ctrl[LSAD_DOS_GAP_BIT] ? LSAD_DEST_PCI : LSAD_DEST_DRAM; // see [R16]
        end
        else if (acc.addr < LSAD_EXP_BASE)
        begin
            if (video_smm_space && acc.init != LSAD_INIT_HOST && acc.init != LSAD_INIT_PCI)
            begin
                dest = LSAD_DEST_NONE; // see [R18]
            end
            else if (video_smm_space && acc.init == LSAD_INIT_HOST && acc.smm)
            begin
                dest = LSAD_DEST_DRAM;
            end
            else
            begin
                dest = vga_to_agp ? LSAD_DEST_AGP : LSAD_DEST_PCI; // see [R17]
            end
        end
        else if (seg_hit)
        begin
            if (acc.init != LSAD_INIT_HOST)
            begin
                // Relies on software keeping such segments read/write, see [R10]
                dest = LSAD_DEST_DRAM; // see [R02]
            end
            else
            begin
                // Unclaimed cycles go out and terminate there, see [R06] [R07] [R08] [R09]
                dest = claim_bit ? LSAD_DEST_DRAM : LSAD_DEST_PCI; // see [R03] [R04]
            end
        end
        else if (acc.addr >= LSAD_GAP_BASE && acc.addr < LSAD_GAP_END &&
                 state.fixed_gap_ctrl[LSAD_GAP_EN_BIT])
        begin
            // No remap: the DRAM behind the gap is simply lost, see [R20]
            dest = LSAD_DEST_PCI; // see [R19]
        end
        else
        begin
            dest = LSAD_DEST_DRAM;
        end

        next_state.route.valid = acc_valid; // see [R22]
        next_state.route.dest = acc_valid ? dest : LSAD_DEST_DRAM;
        next_state.route.claim = acc_valid && dest == LSAD_DEST_DRAM;
        next_state.route.blocked = acc_valid && dest == LSAD_DEST_NONE;
        if (acc_valid)
        begin
            next_state.status = {3'h0, dest == LSAD_DEST_NONE, dest == LSAD_DEST_DRAM, dest};
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state.segment_attribute_map <= '0; // see [R21]
            state.fixed_gap_ctrl <= LSAD_REG_RESET;
            state.dos_ctrl <= LSAD_REG_RESET;
            state.status <= LSAD_REG_RESET;
            state.waitreq <= 1'b1;
            state.rdata <= 32'h0000_0000;
            state.route <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign avs_readdata = state.rdata;
    assign avs_waitrequest = state.waitreq;
    assign route = state.route;

endmodule

/* inc/lsad_pkg.sv */
/*
 * Shared constants and types of the legacy segment attribute decoder:
 * register indices, field positions, masks, reset values, address bounds,
 * and the access request and route result carriers.
 * Assumes a single 100 MHz core clock domain and 32-bit access addresses.
 */
package lsad_pkg;

    // ==========================================================
    // Register indices (byte address on the bus is four times these)
    localparam logic [7:0] LSAD_IDX_BIOS_AREA = 8'h90;
    localparam logic [7:0] LSAD_IDX_ADDON_C0 = 8'h91;
    localparam logic [7:0] LSAD_IDX_ADDON_C8 = 8'h92;
    localparam logic [7:0] LSAD_IDX_ADDON_D0 = 8'h93;
    localparam logic [7:0] LSAD_IDX_ADDON_D8 = 8'h94;
    localparam logic [7:0] LSAD_IDX_BIOS_E0 = 8'h95;
    localparam logic [7:0] LSAD_IDX_BIOS_E8 = 8'h96;
    localparam logic [7:0] LSAD_IDX_GAP_CTRL = 8'h97;
    localparam logic [7:0] LSAD_IDX_DOS_CTRL = 8'h98;
    localparam logic [7:0] LSAD_IDX_STATUS = 8'h99;

    // ==========================================================
    // Field positions and writable masks
    localparam int LSAD_NUM_ATTR = 7;
    localparam int LSAD_NUM_SEG = 13;
    localparam int LSAD_RD_LO = 0;
    localparam int LSAD_WR_LO = 1;
    localparam int LSAD_RD_HI = 4;
    localparam int LSAD_WR_HI = 5;
    localparam int LSAD_GAP_EN_BIT = 7;
    localparam int LSAD_DOS_GAP_BIT = 0;
    localparam logic [7:0] LSAD_ATTR_MASK = 8'h33;
    localparam logic [7:0] LSAD_BIOS_MASK = 8'h30;
    localparam logic [7:0] LSAD_GAP_MASK = 8'h80;
    localparam logic [7:0] LSAD_DOS_MASK = 8'h01;
    localparam logic [7:0] LSAD_REG_RESET = 8'h00;

    // ==========================================================
    // Address map bounds
    localparam logic [31:0] LSAD_DOS_LOW_END = 32'h0008_0000;
    localparam logic [31:0] LSAD_VIDEO_BASE = 32'h000A_0000;
    localparam logic [31:0] LSAD_EXP_BASE = 32'h000C_0000;
    localparam logic [31:0] LSAD_SYS_BIOS_BASE = 32'h000F_0000;
    localparam logic [31:0] LSAD_ONE_MEG = 32'h0010_0000;
    localparam logic [31:0] LSAD_GAP_BASE = 32'h00F0_0000;
    localparam logic [31:0] LSAD_GAP_END = 32'h0100_0000;
    localparam logic [5:0] LSAD_EXP_BLOCK = 6'h30;
    localparam logic [3:0] LSAD_SYS_BIOS_SEG = 4'hC;

    // ==========================================================
    // Carriers
    typedef enum logic [2:0] {
        LSAD_DEST_DRAM = 3'h0,
        LSAD_DEST_HUB = 3'h1,
        LSAD_DEST_PCI = 3'h2,
        LSAD_DEST_AGP = 3'h3,
        LSAD_DEST_NONE = 3'h4
    } lsad_dest_t;

    typedef enum logic [1:0] {
        LSAD_INIT_HOST = 2'h0,
        LSAD_INIT_HUB = 2'h1,
        LSAD_INIT_AGP = 2'h2,
        LSAD_INIT_PCI = 2'h3
    } lsad_init_t;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        lsad_init_t init;
        logic smm;
    } lsad_acc_t;

    typedef struct packed {
        logic valid;
        lsad_dest_t dest;
        logic claim;
        logic blocked;
    } lsad_route_t;

endpackage

/* verif/lsad_decode_properties.sv */
/* Port checker for lsad_decode, bound to every instance.
   Assumes one mclk domain; gap enable is shadowed from bus writes. */
module lsad_decode_properties
    import lsad_pkg::*;
#(
    parameter int AVS_ADDR_W = 8
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [AVS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic acc_valid,
    input wire lsad_acc_t acc,
    input wire logic vga_to_agp,
    input wire logic video_smm_space,
    input wire lsad_route_t route
);
    // ==========================================================
    // Helper logic
    logic gap_en;
    logic in_seg, in_vid, in_gap, non_host;
    assign in_seg = acc.addr >= LSAD_EXP_BASE && acc.addr < LSAD_ONE_MEG;
    assign in_vid = acc.addr >= LSAD_VIDEO_BASE && acc.addr < LSAD_EXP_BASE;
    assign in_gap = acc.addr >= LSAD_GAP_BASE && acc.addr < LSAD_GAP_END;
    assign non_host = acc.init != LSAD_INIT_HOST;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            gap_en <= 1'b0;
        else if (avs_write && !avs_waitrequest && avs_byteenable[0]
                && avs_address == AVS_ADDR_W'(LSAD_IDX_GAP_CTRL))
            gap_en <= avs_writedata[LSAD_GAP_EN_BIT];
    end

    // ==========================================================
    // Assertions
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    route_latency_a: assert property (acc_valid |=> route.valid)
        else $error("route missing after access");
    route_origin_a: assert property (route.valid |-> $past(acc_valid))
        else $error("route without access");
    dos_low_a: assert property (acc_valid && acc.addr < LSAD_DOS_LOW_END
        |=> route.dest == LSAD_DEST_DRAM) else $error("low area not to dram");
    nonhost_seg_a: assert property (acc_valid && in_seg && non_host
        |=> route.dest == LSAD_DEST_DRAM) else $error("non-host segment access");
    video_steer_a: assert property (acc_valid && in_vid && !non_host && !acc.smm
        && vga_to_agp |=> route.dest == LSAD_DEST_AGP) else $error("video not to agp");
    video_block_a: assert property (acc_valid && in_vid && video_smm_space
        && (acc.init == LSAD_INIT_HUB || acc.init == LSAD_INIT_AGP)
        |=> route.blocked && route.dest == LSAD_DEST_NONE) else $error("smm video open");
    gap_open_a: assert property (acc_valid && in_gap && gap_en
        |=> route.dest == LSAD_DEST_PCI) else $error("open gap reached dram");
    gap_closed_a: assert property (acc_valid && in_gap && !gap_en
        |=> route.dest == LSAD_DEST_DRAM) else $error("closed gap not dram");
    wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bad wait state");
    attr_reserved_a: assert property (avs_read && !avs_waitrequest
        && avs_address >= AVS_ADDR_W'(LSAD_IDX_ADDON_C0)
        && avs_address <= AVS_ADDR_W'(LSAD_IDX_BIOS_E8)
        |-> (avs_readdata & ~32'h33) == 32'h0) else $error("reserved bits set");
    bios_reserved_a: assert property (avs_read && !avs_waitrequest
        && avs_address == AVS_ADDR_W'(LSAD_IDX_BIOS_AREA)
        |-> (avs_readdata & ~32'h30) == 32'h0) else $error("bios low field set");
    cover property (route.valid && route.blocked);
    cover property (acc_valid && in_gap && gap_en);
    cover property (avs_write && !avs_waitrequest);
endmodule

bind lsad_decode lsad_decode_properties #(.AVS_ADDR_W(AVS_ADDR_W)) u_props (
    .mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .acc_valid(acc_valid),
    .acc(acc), .vga_to_agp(vga_to_agp), .video_smm_space(video_smm_space), .route(route));

/* verif/lsad_initiator_model.sv */
/* Stand-in for host, hub and AGP initiators: a command becomes one access pulse.
   Assumes commands change just after a rising edge of mclk. */
module lsad_initiator_model
    import lsad_pkg::*;
(
    input wire logic mclk,
    input wire logic issue,
    input wire lsad_acc_t req,
    output logic acc_valid,
    output lsad_acc_t acc
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        acc_valid = 1'b0;
        acc = '0;
    end
    // Idle bus toggles so stale fields never pass for a request
    always @(posedge mclk)
    begin
        acc_valid <= issue;
        acc <= issue ? req : ~acc;
    end
endmodule

/* verif/lsad_decode_bench.sv */
/* Self-checking bench of lsad_decode: registers, segment modes, fixed map.
   Assumes the initiator model and the bound checker are compiled alongside. */
module lsad_decode_bench
    import lsad_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset_n, avs_read, avs_write, avs_waitrequest, acc_valid, issue;
    logic vga_to_agp, video_smm_space;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    lsad_acc_t acc, req;
    lsad_route_t route;
    int n_errors, tests_run, cycles;

    lsad_decode #(.AVS_ADDR_W(8)) i_dut (.mclk(mclk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .acc_valid(acc_valid), .acc(acc), .vga_to_agp(vga_to_agp),
        .video_smm_space(video_smm_space), .route(route));
    lsad_initiator_model i_init (.mclk(mclk), .issue(issue), .req(req),
        .acc_valid(acc_valid), .acc(acc));

    // ==========================================================
    // Compare, bus and access tasks
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_route(input logic [5:0] got, input logic [5:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge mclk);
        avs_address <= idx;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h0, q);
        chk_reg(q, exp);
    endtask
    task automatic access(input logic [31:0] a, input logic w, input lsad_init_t i,
                          input lsad_dest_t d, input logic b);
        logic [5:0] e;
        e = {1'b1, d, d == LSAD_DEST_DRAM, b};
        @(posedge mclk);
        req <= '{addr: a, write: w, init: i, smm: 1'b0};
        issue <= 1'b1;
        @(posedge mclk);
        issue <= 1'b0;
        // Route launched one edge earlier still stands at this edge
        repeat (2) @(posedge mclk);
        chk_route({route.valid, route.dest, route.claim, route.blocked}, e);
    endtask
    function automatic logic [1:0] md(int k, int r);
        return 2'((k + r) % 4);
    endfunction

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        for (int j = 0; j < 8; j++)
        begin
            rd(LSAD_IDX_BIOS_AREA + 8'(j), 32'h0);
            wr(LSAD_IDX_BIOS_AREA + 8'(j), 8'hFF);
            rd(LSAD_IDX_BIOS_AREA + 8'(j), j == 0 ? 32'h30 : j == 7 ? 32'h80 : 32'h33);
        end
        avs_byteenable <= 4'h0;
        wr(LSAD_IDX_GAP_CTRL, 8'h00);
        avs_byteenable <= 4'hF;
        rd(LSAD_IDX_GAP_CTRL, 32'h80);
        wr(8'hA0, 8'hFF);
        rd(8'hA0, 32'h0);
    endtask
    // Each pass rotates the mode per segment so neighbouring fields differ
    task automatic t_segments();
        logic [1:0] m;
        logic [31:0] a;
        for (int r = 0; r < 4; r++)
        begin
            wr(LSAD_IDX_BIOS_AREA, {2'h0, md(12, r), 4'h0});
            for (int j = 0; j < 6; j++)
                wr(LSAD_IDX_ADDON_C0 + 8'(j), {2'h0, md(2*j+1, r), 2'h0, md(2*j, r)});
            for (int k = 0; k < 13; k++)
            begin
                m = md(k, r);
                a = (k < 12) ? 32'hC3FFF + 32'(k) * 32'h4000 : 32'hFFFFF;
                access(a, 1'b0, LSAD_INIT_HOST, m[0] ? LSAD_DEST_DRAM : LSAD_DEST_PCI, 1'b0);
                access(a, 1'b1, LSAD_INIT_HOST, m[1] ? LSAD_DEST_DRAM : LSAD_DEST_PCI, 1'b0);
                if (m == 2'h3)
                    access(a, 1'b1, LSAD_INIT_HUB, LSAD_DEST_DRAM, 1'b0);
            end
        end
        // Firmware shadow: write-only while copying, read-only afterwards
        wr(LSAD_IDX_BIOS_AREA, 8'h20);
        access(32'hF_0000, 1'b0, LSAD_INIT_HOST, LSAD_DEST_PCI, 1'b0);
        access(32'hF_0000, 1'b1, LSAD_INIT_HOST, LSAD_DEST_DRAM, 1'b0);
        wr(LSAD_IDX_BIOS_AREA, 8'h10);
        access(32'hF_0000, 1'b0, LSAD_INIT_HOST, LSAD_DEST_DRAM, 1'b0);
        access(32'hF_0000, 1'b1, LSAD_INIT_HOST, LSAD_DEST_PCI, 1'b0);
    endtask
    task automatic t_map();
        wr(LSAD_IDX_GAP_CTRL, 8'h00);
        access(32'h0, 1'b1, LSAD_INIT_HOST, LSAD_DEST_DRAM, 1'b0);
        access(32'h8_0000, 1'b0, LSAD_INIT_HOST, LSAD_DEST_DRAM, 1'b0);
        wr(LSAD_IDX_DOS_CTRL, 8'hFF);
        rd(LSAD_IDX_DOS_CTRL, 32'h01);
        access(32'h9_FFFF, 1'b0, LSAD_INIT_HOST, LSAD_DEST_PCI, 1'b0);
        access(32'h7_FFFF, 1'b0, LSAD_INIT_HOST, LSAD_DEST_DRAM, 1'b0);
        vga_to_agp <= 1'b1;
        access(LSAD_VIDEO_BASE, 1'b0, LSAD_INIT_HOST, LSAD_DEST_AGP, 1'b0);
        vga_to_agp <= 1'b0;
        access(32'hB_FFFF, 1'b1, LSAD_INIT_HOST, LSAD_DEST_PCI, 1'b0);
        video_smm_space <= 1'b1;
        access(32'hA_8000, 1'b0, LSAD_INIT_HUB, LSAD_DEST_NONE, 1'b1);
        access(32'hA_8000, 1'b1, LSAD_INIT_AGP, LSAD_DEST_NONE, 1'b1);
        rd(LSAD_IDX_STATUS, 32'h14);
        video_smm_space <= 1'b0;
        access(32'hF0_0000, 1'b0, LSAD_INIT_HOST, LSAD_DEST_DRAM, 1'b0);
        wr(LSAD_IDX_GAP_CTRL, 8'h80);
        access(32'hF0_0000, 1'b0, LSAD_INIT_HOST, LSAD_DEST_PCI, 1'b0);
        access(32'hFF_FFFF, 1'b1, LSAD_INIT_HUB, LSAD_DEST_PCI, 1'b0);
        access(32'h100_0000, 1'b0, LSAD_INIT_HOST, LSAD_DEST_DRAM, 1'b0);
        access(32'hEF_FFFF, 1'b1, LSAD_INIT_HOST, LSAD_DEST_DRAM, 1'b0);
        rd(LSAD_IDX_STATUS, 32'h08);
    endtask

    // ==========================================================
    // Run control
    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Ceiling well above the roughly 740 cycles the run needs
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    initial
    begin
        {reset_n, avs_read, avs_write, issue, vga_to_agp, video_smm_space} = '0;
        avs_address = 8'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        req = '0;
        {n_errors, tests_run, cycles} = '0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        t_regs();
        t_segments();
        t_map();
        print_verdict();
    end
endmodule
